// ---- design/tras_loop_code.sv ----
// repeating loop code detector integrated over a fixed bit window
`timescale 1ns/1ns
`default_nettype none
module tras_loop_code #(
  parameter int PERIOD      = 5,
  parameter int WINDOW_BITS = 74074
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // received bits
  input  wire logic bit_strobe,
  input  wire logic bit_value,
  // result
  output logic      code_seen
);
  localparam logic [16:0] LAST    = 17'(WINDOW_BITS - 1);
  // 1/32 error budget comfortably covers a 1e-2 error rate
  localparam logic [16:0] ERR_MAX = 17'(WINDOW_BITS / 32);
  localparam logic [16:0] ONE_MIN = 17'(WINDOW_BITS / 8);
  localparam logic [16:0] ONE_MAX = 17'(WINDOW_BITS / 2);

  logic [PERIOD-1:0] history;
  logic [16:0]       bit_cnt;
  logic [16:0]       err_cnt;
  logic [16:0]       one_cnt;

  wire mismatch   = bit_value != history[PERIOD-1];
  wire window_end = bit_strobe && (bit_cnt == LAST);
  wire verdict    = (err_cnt < ERR_MAX) && (one_cnt > ONE_MIN) && (one_cnt < ONE_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      history   <= '0;
      bit_cnt   <= 17'h00000;
      err_cnt   <= 17'h00000;
      one_cnt   <= 17'h00000;
      code_seen <= 1'b0;
    end else if (bit_strobe) begin
      history <= {history[PERIOD-2:0], bit_value};
      if (window_end) begin
        bit_cnt   <= 17'h00000;
        err_cnt   <= 17'h00000;
        one_cnt   <= 17'h00000;
        code_seen <= verdict;
      end else begin
        bit_cnt <= bit_cnt + 17'h00001;
        err_cnt <= err_cnt + {16'h0000, mismatch};
        one_cnt <= one_cnt + {16'h0000, bit_value};
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/tras_params.svh ----
// offsets, field positions, reset values and timing counts of the receive alarm block
`ifndef TRAS_PARAMS_SVH
`define TRAS_PARAMS_SVH

`define TRAS_ADDR_STATUS_ONE     8'h20
`define TRAS_ADDR_CONTROL        8'h24
`define TRAS_CTRL_RESET          4'h0
`define TRAS_STATUS_RESET        8'h00

`define TRAS_CTRL_PIN_EN_BIT     0
`define TRAS_CTRL_FALLBACK_BIT   1
`define TRAS_CTRL_VARIANT_BIT    2
`define TRAS_CTRL_ESF_BIT        3

`define TRAS_RESP_OKAY           2'h0
`define TRAS_RESP_SLVERR         2'h2

// line bit period at 1.544 Mbit/s, rounded up
`define TRAS_BIT_PERIOD_NS       648
`define TRAS_TXCLK_LOSS_NS       5200
`define TRAS_TXCLK_LOSS_BITS     ((`TRAS_TXCLK_LOSS_NS) / (`TRAS_BIT_PERIOD_NS))
`define TRAS_AIS_WINDOW_MS       3
`define TRAS_AIS_WINDOW_BITS     ((`TRAS_AIS_WINDOW_MS * 1000000) / (`TRAS_BIT_PERIOD_NS))
`define TRAS_AIS_SET_MAX_ZEROS   5
`define TRAS_LOOP_WINDOW_MS      48
`define TRAS_LOOP_WINDOW_BITS    ((`TRAS_LOOP_WINDOW_MS * 1000000) / (`TRAS_BIT_PERIOD_NS))
`define TRAS_LOOP_UP_PERIOD      5
`define TRAS_LOOP_DOWN_PERIOD    3

`define TRAS_RAI_D4_CHANNELS     256
`define TRAS_RAI_D4_MIN_ZEROS    254
`define TRAS_RAI_ESF_PATTERN     16'h00FF
`define TRAS_RAI_ESF_RUN         16
`define TRAS_RAI_ESF_CLEAR_MAX   14

`define TRAS_RCL_ZERO_RUN        192
`define TRAS_RCL_WINDOW          112
`define TRAS_RCL_MIN_ONES        14

`endif

// ---- design/tras_pkg.sv ----
// types shared by the receive alarm block
package tras_pkg;

  typedef struct packed {
    logic esf_mode;
    logic remote_alarm_variant_select;
    logic tx_clock_fallback_enable;
    logic alarm_pin_enable;
  } tras_ctrl_t;

  typedef struct packed {
    logic loop_up_seen;
    logic loop_down_seen;
    logic tx_clock_lost;
    logic rx_buffer_slip;
    logic rx_ais_flag;
    logic rx_remote_alarm_flag;
    logic rx_carrier_lost;
    logic rx_frame_lost;
  } tras_status_t;

  typedef enum logic [1:0] {
    TRAS_CL_NORMAL  = 2'b00,
    TRAS_CL_LOST    = 2'b01,
    TRAS_CL_RECOVER = 2'b10
  } tras_cl_state_t;

endpackage

// ---- design/tras_sync.sv ----
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module tras_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // signals
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule
`default_nettype wire

// ---- design/tras_top.sv ----
// receive alarm detection and status register one of a t1 framer, axi4-lite slave
// Notes on behaviour
// - 8-bit status register at 0x20: loop up, loop down, tx clock lost, slip, blue, yellow, carrier, frame.
// - tx clock lost after one channel time (5.2 us) without tx clock transition, timed by rx clock.
// - with alarm pin enable set, tx clock loss drives the shared alarm pin high.
// - with fallback enable set, tx clock loss switches the transmit formatter to the rx clock.
// - blue alarm declared when five or fewer zeros arrive in a 3 ms window.
// - blue alarm cleared when six or more zeros arrive in a 3 ms window.
// - blue detector tolerates 1e-3 errors and ignores framed all ones.
// - yellow flag set when the selected framing mode's yellow condition is seen on the rails.
// - d4 bit 2 mode: declare at 254 or more zeros of 256 channels, else clear.
// - twelfth framing bit mode: declare after two consecutive ones in that bit.
// - twelfth framing bit mode: clear after two consecutive zeros in that bit.
// - esf mode: declare after sixteen consecutive 00FF data link patterns.
// - esf mode: clear when fourteen or fewer of sixteen patterns equal 00FF.
// - carrier loss declared after 192 consecutive zeros.
// - carrier loss cleared by 14 ones within 112 bits from the first one.
// - bits 7 and 6 report loop up and loop down codes, framed or unframed.
// - loop code detection integrates about 48 ms and tolerates 1e-2 error rate.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tras_params.svh"
module tras_top
  import tras_pkg::*;
#(
  parameter int AIS_WINDOW_BITS  = `TRAS_AIS_WINDOW_BITS,
  parameter int LOOP_WINDOW_BITS = `TRAS_LOOP_WINDOW_BITS
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // axi4-lite write address
  input  wire logic [7:0] awaddr,
  input  wire logic [2:0] awprot,
  input  wire logic       awvalid,
  output logic            awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // line pins
  input  wire logic        rx_line_clock,
  input  wire logic        rx_plus_rail,
  input  wire logic        rx_minus_rail,
  input  wire logic        tx_line_clock,
  // framer context, sampled at rx clock rise except rx_in_sync, which is taken every aclk cycle
  input  wire logic        rx_in_sync,
  input  wire logic        rx_slip_seen,
  input  wire logic        rx_at_chan_bit2,
  input  wire logic        rx_at_fbit12,
  input  wire logic        rx_at_fdl_bit,
  // alarm outputs
  output logic             frame_or_clock_loss_pin,
  output logic             tx_run_from_rx_clock
);
  localparam logic [12:0] AIS_LAST  = 13'(AIS_WINDOW_BITS - 1);
  localparam logic [3:0]  TXC_LIMIT = 4'(`TRAS_TXCLK_LOSS_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and rx clock edge finding
  logic [8:0] pins_s;
  logic       rclk_q;
  logic       tx_line_clock_q;

  tras_sync #(.WIDTH(9)) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({rx_line_clock, rx_plus_rail, rx_minus_rail, tx_line_clock, rx_in_sync,
                rx_slip_seen, rx_at_chan_bit2, rx_at_fbit12, rx_at_fdl_bit}),
    .sync_out (pins_s)
  );

  wire rclk_s    = pins_s[8];
  wire tx_line_clock_s    = pins_s[5];
  wire rx_rise   = rclk_s && !rclk_q;
  wire rx_one    = pins_s[7] || pins_s[6];
  wire in_sync_s = pins_s[4];
  wire slip_s    = pins_s[3];
  wire at_bit2   = pins_s[2];
  wire at_fbit12 = pins_s[1];
  wire at_fdl    = pins_s[0];
  wire tx_toggle = tx_line_clock_s != tx_line_clock_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rclk_q <= 1'b0;
      tx_line_clock_q <= 1'b0;
    end else begin
      rclk_q <= rclk_s;
      tx_line_clock_q <= tx_line_clock_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit clock watchdog, counted in rx clock periods
  logic [3:0] txc_cnt;
  logic       txc_lost;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txc_cnt  <= 4'h0;
      txc_lost <= 1'b0;
    end else if (tx_toggle) begin
      txc_cnt  <= 4'h0;
      txc_lost <= 1'b0;
    end else if (rx_rise && !txc_lost) begin
      txc_cnt  <= txc_cnt + 4'h1;
      txc_lost <= (txc_cnt + 4'h1) >= TXC_LIMIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blue alarm: zeros counted over a fixed window
  // a zero budget of five rides out 1e-3 errors; framing bits of a framed all-ones signal exceed it
  logic [12:0] ais_bits;
  logic [2:0]  ais_zeros;
  logic        ais_active;

  wire ais_end = rx_rise && (ais_bits == AIS_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ais_bits   <= 13'h0000;
      ais_zeros  <= 3'h0;
      ais_active <= 1'b0;
    end else if (ais_end) begin
      ais_bits   <= 13'h0000;
      ais_zeros  <= 3'h0;
      // one bit wider, so a saturated count plus a last zero cannot wrap to a false blue
      ais_active <= ({1'b0, ais_zeros} + {3'h0, !rx_one}) <= 4'(`TRAS_AIS_SET_MAX_ZEROS);
    end else if (rx_rise) begin
      ais_bits <= ais_bits + 13'h0001;
      if (!rx_one && ais_zeros != 3'h7)
        ais_zeros <= ais_zeros + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carrier loss: zero run to declare, ones within a window to clear
  tras_cl_state_t cl_state;
  tras_cl_state_t next_cl_state;
  logic [7:0]     cl_zero_run;
  logic [6:0]     cl_win;
  logic [3:0]     cl_ones;

  wire cl_run_full = (cl_zero_run == 8'(`TRAS_RCL_ZERO_RUN - 1)) && !rx_one;
  wire cl_ones_ok  = (cl_ones + {3'h0, rx_one}) >= 4'(`TRAS_RCL_MIN_ONES);
  wire cl_win_end  = cl_win == 7'(`TRAS_RCL_WINDOW - 1);

  always_comb begin
    next_cl_state = cl_state;
    case (cl_state)
      TRAS_CL_NORMAL: begin
        if (rx_rise && cl_run_full)
          next_cl_state = TRAS_CL_LOST;
      end
      TRAS_CL_LOST: begin
        if (rx_rise && rx_one)
          next_cl_state = TRAS_CL_RECOVER;
      end
      TRAS_CL_RECOVER: begin
        if (rx_rise && cl_ones_ok)
          next_cl_state = TRAS_CL_NORMAL;
        else if (rx_rise && cl_win_end)
          next_cl_state = TRAS_CL_LOST;
      end
      default: next_cl_state = TRAS_CL_LOST;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cl_state    <= TRAS_CL_NORMAL;
      cl_zero_run <= 8'h00;
      cl_win      <= 7'h00;
      cl_ones     <= 4'h0;
    end else begin
      cl_state <= next_cl_state;
      if (rx_rise) begin
        cl_zero_run <= (rx_one || cl_run_full) ? 8'h00 : cl_zero_run + 8'h01;
        // the first one counts as bit one of the window
        if (cl_state == TRAS_CL_LOST) begin
          cl_win  <= 7'h01;
          cl_ones <= 4'h1;
        end else if (cl_state == TRAS_CL_RECOVER) begin
          cl_win  <= cl_win + 7'h01;
          cl_ones <= cl_ones + {3'h0, rx_one};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // yellow alarm, three framing variants
  tras_ctrl_t  ctrl;
  logic [8:0]  d4_chans;
  logic [8:0]  d4_zeros;
  logic [1:0]  f12_hist;
  logic [15:0] fdl_shift;
  logic [3:0]  fdl_bits;
  logic [4:0]  esf_run;
  logic [3:0]  esf_groups;
  logic [4:0]  esf_hits;
  logic        rai_active;

  wire d4_step   = rx_rise && at_bit2;
  wire d4_end    = d4_step && (d4_chans == 9'(`TRAS_RAI_D4_CHANNELS - 1));
  wire [8:0] d4_total = d4_zeros + {8'h00, !rx_one};
  wire f12_step  = rx_rise && at_fbit12;
  wire fdl_step  = rx_rise && at_fdl;
  wire [15:0] fdl_word = {fdl_shift[14:0], rx_one};
  wire pat_done  = fdl_step && (fdl_bits == 4'hF);
  wire pat_hit   = fdl_word == `TRAS_RAI_ESF_PATTERN;
  wire [4:0] hits_now = esf_hits + {4'h0, pat_hit};
  wire grp_done  = pat_done && (esf_groups == 4'hF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d4_chans   <= 9'h000;
      d4_zeros   <= 9'h000;
      f12_hist   <= 2'h0;
      fdl_shift  <= 16'h0000;
      fdl_bits   <= 4'h0;
      esf_run    <= 5'h00;
      esf_groups <= 4'h0;
      esf_hits   <= 5'h00;
      rai_active <= 1'b0;
    end else begin
      if (d4_step) begin
        d4_chans <= d4_end ? 9'h000 : d4_chans + 9'h001;
        d4_zeros <= d4_end ? 9'h000 : d4_total;
      end
      if (f12_step)
        f12_hist <= {f12_hist[0], rx_one};
      if (fdl_step) begin
        fdl_shift <= fdl_word;
        fdl_bits  <= fdl_bits + 4'h1;
      end
      if (pat_done) begin
        esf_run    <= pat_hit ? ((esf_run == 5'(`TRAS_RAI_ESF_RUN)) ? esf_run : esf_run + 5'h01) : 5'h00;
        esf_groups <= esf_groups + 4'h1;
        esf_hits   <= grp_done ? 5'h00 : hits_now;
      end
      if (ctrl.esf_mode) begin
        if (pat_done && pat_hit && esf_run == 5'(`TRAS_RAI_ESF_RUN - 1))
          rai_active <= 1'b1;
        else if (grp_done && hits_now <= 5'(`TRAS_RAI_ESF_CLEAR_MAX))
          rai_active <= 1'b0;
      end else if (ctrl.remote_alarm_variant_select) begin
        if (f12_step && rx_one && f12_hist[0])
          rai_active <= 1'b1;
        else if (f12_step && !rx_one && !f12_hist[0])
          rai_active <= 1'b0;
      end else if (d4_end) begin
        rai_active <= d4_total >= 9'(`TRAS_RAI_D4_MIN_ZEROS);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop codes, tracked in framed and unframed signals alike
  logic loop_up_det;
  logic loop_down_det;

  tras_loop_code #(.PERIOD(`TRAS_LOOP_UP_PERIOD), .WINDOW_BITS(LOOP_WINDOW_BITS)) u_loop_up (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .bit_strobe (rx_rise),
    .bit_value  (rx_one),
    .code_seen  (loop_up_det)
  );

  tras_loop_code #(.PERIOD(`TRAS_LOOP_DOWN_PERIOD), .WINDOW_BITS(LOOP_WINDOW_BITS)) u_loop_down (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .bit_strobe (rx_rise),
    .bit_value  (rx_one),
    .code_seen  (loop_down_det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status flags: set wins over the clear that a read makes
  tras_status_t status;
  tras_status_t status_set;
  logic [7:0]   status_bits;

  assign status_set.loop_up_seen         = loop_up_det;
  assign status_set.loop_down_seen       = loop_down_det;
  assign status_set.tx_clock_lost        = txc_lost;
  assign status_set.rx_buffer_slip       = rx_rise && slip_s;
  assign status_set.rx_ais_flag          = ais_active;
  assign status_set.rx_remote_alarm_flag = rai_active;
  assign status_set.rx_carrier_lost      = cl_state != TRAS_CL_NORMAL;
  assign status_set.rx_frame_lost        = !in_sync_s;

  wire rd_take      = arvalid && arready;
  wire rd_status    = araddr == `TRAS_ADDR_STATUS_ONE;
  wire rd_control   = araddr == `TRAS_ADDR_CONTROL;
  wire status_clear = rd_take && rd_status;

  generate
    for (genvar i = 0; i < 8; i++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn)
          status_bits[i] <= 1'b0;
        else
          status_bits[i] <= status_set[i] || (status_bits[i] && !status_clear);
      end
    end
  endgenerate

  assign status = status_bits;

  ////////////////////////////////////////////////////////////////////////////
  // alarm pin and transmit clock fallback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_or_clock_loss_pin <= 1'b0;
      tx_run_from_rx_clock    <= 1'b0;
    end else begin
      frame_or_clock_loss_pin <= !in_sync_s || (ctrl.alarm_pin_enable && txc_lost);
      tx_run_from_rx_clock    <= ctrl.tx_clock_fallback_enable && txc_lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, one write and one read at a time
  logic [7:0] aw_addr_q;
  logic       aw_held;
  logic       w_held;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  wire wr_go      = aw_held && w_held && !bvalid;
  wire wr_control = aw_addr_q == `TRAS_ADDR_CONTROL;
  wire wr_status  = aw_addr_q == `TRAS_ADDR_STATUS_ONE;
  wire [31:0] rd_word = rd_status ? {24'h000000, status} :
                        rd_control ? {28'h0000000, ctrl} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `TRAS_RESP_OKAY;
      ctrl      <= `TRAS_CTRL_RESET;
    end else begin
      awready <= !aw_held && !(awvalid && awready) && !bvalid;
      wready  <= !w_held && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wr_control || wr_status) ? `TRAS_RESP_OKAY : `TRAS_RESP_SLVERR;
        if (wr_control && w_strb_q[0])
          ctrl <= w_data_q[3:0];
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `TRAS_RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= (rd_status || rd_control) ? `TRAS_RESP_OKAY : `TRAS_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- testbench/tras_chk.sv ----
// port assertions of the receive alarm block
`timescale 1ns/1ns
`default_nettype none
`include "tras_params.svh"
module tras_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // line and alarms
  input wire logic        rx_in_sync,
  input wire logic        tx_line_clock,
  input wire logic        frame_or_clock_loss_pin,
  input wire logic        tx_run_from_rx_clock
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] quiet;
  logic       ar_st;
  logic       ar_un;
  assign ar_st = arvalid && arready && araddr == `TRAS_ADDR_STATUS_ONE;
  assign ar_un = arvalid && arready && araddr != `TRAS_ADDR_STATUS_ONE && araddr != `TRAS_ADDR_CONTROL;
  // aclk cycles since the transmit clock pin last moved
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_line_clock != $past(tx_line_clock)) quiet <= 8'h00;
    else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
  end
  property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer changed before rready");
  property p_wr_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer changed before bready");
  property p_unmap; ar_un |-> ##[1:2] (rvalid && rresp == `TRAS_RESP_SLVERR && rdata == 32'h0); endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_status; ar_st |-> ##[1:2] (rvalid && rresp == `TRAS_RESP_OKAY && rdata[31:8] == 24'h0); endproperty
  a_status: assert property (p_status) else $error("status word malformed");
  property p_frame; (!rx_in_sync) [*6] ##0 ar_st |-> ##[1:2] (rvalid && rdata[0]); endproperty
  a_frame: assert property (p_frame) else $error("frame loss flag missing");
  property p_pin_sync; (!rx_in_sync) [*6] |-> frame_or_clock_loss_pin; endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("shared pin low while out of sync");
  property p_tx_clear; tx_line_clock != $past(tx_line_clock) |-> ##[1:8] !tx_run_from_rx_clock; endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("fallback kept with live tx clock");
  property p_tx_quiet; $rose(tx_run_from_rx_clock) |-> quiet >= 8'h32; endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("fallback too early");
endmodule
bind tras_top tras_chk chk (.*);
`default_nettype wire

// ---- testbench/tras_line_model.sv ----
// t1 line side: receive clock, rails, framing strobes, transmit clock
`timescale 1ns/1ns
`default_nettype none
`include "tras_params.svh"
module tras_line_model (
  // pattern choice
  input  wire logic [2:0] mode,
  input  wire logic       tx_on,
  // line pins
  output logic            rx_line_clock,
  output logic            rx_plus_rail,
  output logic            rx_minus_rail,
  output logic            tx_line_clock,
  // framing strobes
  output logic            rx_at_chan_bit2,
  output logic            rx_at_fbit12,
  output logic            rx_at_fdl_bit
);
  int unsigned cnt;
  logic        b;
  logic        pol;
  localparam logic [15:0] FDL_WORD = `TRAS_RAI_ESF_PATTERN;
  initial begin
    cnt = 0;
    pol = 1'b0;
    {rx_line_clock, rx_plus_rail, rx_minus_rail, tx_line_clock} = 4'h0;
    {rx_at_chan_bit2, rx_at_fbit12, rx_at_fdl_bit} = 3'h0;
  end
  always #160 rx_line_clock = !rx_line_clock;
  // stands still when stopped, so the loss detector sees silence
  always #162 if (tx_on) tx_line_clock = !tx_line_clock;
  // new bit on the falling edge, stable at the sampling rise
  always @(negedge rx_line_clock) begin
    cnt = cnt + 1;
    case (mode)
      3'h0: b = 1'b1;
      3'h1: b = 1'b0;
      3'h2: b = (cnt % 5) == 0;
      3'h3: b = (cnt % 3) == 0;
      // words line up with the receiver's groups: reset ends before the first data link strobe
      3'h5: b = ((cnt % 4) == 3) ? FDL_WORD[15 - (cnt / 4) % 16] : 1'b1;
      default: b = 1'($urandom_range(1));
    endcase
    pol = pol ^ b;
    rx_plus_rail = b & pol;
    rx_minus_rail = b & !pol;
    rx_at_chan_bit2 = (cnt % 4) == 1;
    rx_at_fbit12 = (cnt % 16) == 0;
    rx_at_fdl_bit = (cnt % 4) == 3;
  end
endmodule
`default_nettype wire

// ---- testbench/tras_top_tb.sv ----
// self-checking bench of the receive alarm block
`timescale 1ns/1ns
`default_nettype none
`include "tras_params.svh"
module tras_top_tb
  import tras_pkg::*;
;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_in_sync, rx_slip_seen, tx_on;
  logic        rx_line_clock, rx_plus_rail, rx_minus_rail, tx_line_clock;
  logic        rx_at_chan_bit2, rx_at_fbit12, rx_at_fdl_bit, frame_or_clock_loss_pin, tx_run_from_rx_clock;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp;
  logic [2:0]  mode;
  logic [33:0] exp_v[$];
  logic [31:0] exp_m[$];
  logic [1:0]  exp_b[$];
  int          n_fail, check_count;
  // short windows keep the run brief
  tras_top #(.AIS_WINDOW_BITS(64), .LOOP_WINDOW_BITS(300)) uut (.awprot(3'h0), .arprot(3'h0), .wstrb(4'hF), .*);
  tras_line_model line (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = !aclk;
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bits(input int n);
    repeat (n * 8) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    exp_b.push_back(e);
    // an edge between calls, so no strobe is assigned twice in one step
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
    exp_v.push_back(e);
    exp_m.push_back(m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // status read, only the status bits under m are compared; rresp and bits 31:8 are compared too
  task automatic sr(input logic [7:0] v, input logic [7:0] m);
    rd(`TRAS_ADDR_STATUS_ONE, {26'h0, v & m}, {24'hFFFFFF, m});
  endtask
  task automatic pins(input logic [1:0] e);
    check(34'({frame_or_clock_loss_pin, tx_run_from_rx_clock}), 34'(e));
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) check({rresp, rdata & exp_m.pop_front()}, exp_v.pop_front());
    if (bvalid && bready) check(34'(bresp), 34'(exp_b.pop_front()));
  end
  initial begin
    repeat (80000) @(posedge aclk);
    n_fail++;
    results();
  end
  initial begin
    void'($urandom(65566));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rx_in_sync, rx_slip_seen} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    tx_on = 1'b1;
    mode = 3'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    bits(1);
    pins(2'b10);
    rd(`TRAS_ADDR_CONTROL, 34'h0, 32'hFFFFFFFF);
    rd(8'h30, {`TRAS_RESP_SLVERR, 32'h0}, 32'hFFFFFFFF);
    wr(8'h30, 32'hFFFFFFFF, `TRAS_RESP_SLVERR);
    wr(`TRAS_ADDR_STATUS_ONE, 32'hFFFFFFFF, `TRAS_RESP_OKAY);
    d = $urandom;
    wr(`TRAS_ADDR_CONTROL, d, `TRAS_RESP_OKAY);
    rd(`TRAS_ADDR_CONTROL, {30'h0, d[3:0]}, 32'hFFFFFFFF);
    wr(`TRAS_ADDR_CONTROL, 32'h0, `TRAS_RESP_OKAY);
    sr(8'h01, 8'h01);
    rx_in_sync <= 1'b1;
    bits(1);
    sr(8'h01, 8'h01);
    sr(8'h00, 8'h01);
    rx_slip_seen <= 1'b1;
    bits(1);
    rx_slip_seen <= 1'b0;
    bits(1);
    sr(8'h10, 8'h10);
    sr(8'h00, 8'h10);
    bits(140);
    sr(8'h08, 8'h0B);
    mode <= 3'h4;
    bits(140);
    sr(8'h08, 8'h08);
    sr(8'h00, 8'h08);
    mode <= 3'h1;
    bits(180);
    sr(8'h00, 8'h02);
    bits(20);
    sr(8'h02, 8'h02);
    mode <= 3'h0;
    bits(8);
    sr(8'h02, 8'h02);
    bits(12);
    sr(8'h02, 8'h02);
    sr(8'h00, 8'h02);
    tx_on <= 1'b0;
    bits(5);
    sr(8'h00, 8'h20);
    bits(15);
    pins(2'b00);
    wr(`TRAS_ADDR_CONTROL, 32'h3, `TRAS_RESP_OKAY);
    bits(1);
    pins(2'b11);
    sr(8'h20, 8'h20);
    tx_on <= 1'b1;
    bits(2);
    pins(2'b00);
    sr(8'h20, 8'h20);
    sr(8'h00, 8'h20);
    mode <= 3'h2;
    bits(650);
    sr(8'h80, 8'hC0);
    mode <= 3'h3;
    bits(650);
    sr(8'h40, 8'h40);
    sr(8'h40, 8'hC0);
    wr(`TRAS_ADDR_CONTROL, 32'h4, `TRAS_RESP_OKAY);
    mode <= 3'h0;
    bits(40);
    sr(8'h04, 8'h04);
    mode <= 3'h1;
    bits(40);
    sr(8'h04, 8'h04);
    sr(8'h00, 8'h04);
    wr(`TRAS_ADDR_CONTROL, 32'h0, `TRAS_RESP_OKAY);
    bits(2100);
    sr(8'h04, 8'h04);
    mode <= 3'h0;
    bits(2100);
    sr(8'h04, 8'h04);
    sr(8'h00, 8'h04);
    wr(`TRAS_ADDR_CONTROL, 32'h8, `TRAS_RESP_OKAY);
    mode <= 3'h5;
    bits(1300);
    sr(8'h04, 8'h04);
    mode <= 3'h0;
    bits(1300);
    sr(8'h04, 8'h04);
    sr(8'h00, 8'h04);
    results();
  end
endmodule
`default_nettype wire
